// *** design/scm_pkg.sv ***
// constants, types and the address map of the statistics counter memory
//
// Overview of operation
// - routing register: type 30:26, flow 23:16, queue manager 15:14, queue 11:0
// - writing the go bit starts an unabortable operation; reads set until done
// - 4096 independent 32-bit counters, indexes 0 to 4095
// - query window: counter N at byte offset 4*N
// - collect window: counter N at byte offset 0x4000 plus 4*N
// - query read returns the value and leaves the counter alone
// - collect read returns the value, then clears the counter to zero
// - counters are 32 bits, reset to zero, a full-word bus write loads a value
// - increment and bus write on one counter together: increment wins
package scm_pkg;

  // ==========================================================================
  // sizes
  localparam int unsigned SCM_DATA_W   = 32;
  localparam int unsigned SCM_ADDR_W   = 16;
  localparam int unsigned SCM_IDX_W    = 12;
  localparam int unsigned SCM_NUM_CNT  = 4096;
  localparam logic [11:0] SCM_LAST_IDX = 12'hFFF; // sweep stops after this

  // ==========================================================================
  // address map (byte addresses)
  localparam logic [15:0] SCM_QUERY_BASE   = 16'h0000;
  localparam logic [15:0] SCM_COLLECT_BASE = 16'h4000;
  localparam logic [15:0] SCM_ROUTE_ADDR   = 16'h8000;
  localparam int unsigned SCM_IDX_LSB      = 2;
  localparam int unsigned SCM_WIN_BIT      = 14;  // picks query or collect
  localparam int unsigned SCM_ARR_BIT      = 15;  // above both windows

  // ==========================================================================
  // routing register fields and reset value
  localparam int unsigned SCM_GO_BIT       = 31;
  localparam int unsigned SCM_PTYPE_HI     = 30;
  localparam int unsigned SCM_PTYPE_LO     = 26;
  localparam int unsigned SCM_FLOW_HI      = 23;
  localparam int unsigned SCM_FLOW_LO      = 16;
  localparam int unsigned SCM_QMGR_HI      = 15;
  localparam int unsigned SCM_QMGR_LO      = 14;
  localparam int unsigned SCM_QNUM_HI      = 11;
  localparam int unsigned SCM_QNUM_LO      = 0;
  localparam logic [31:0] SCM_ROUTE_RW_MSK = 32'h7CFFCFFF;
  localparam logic [31:0] SCM_ROUTE_RST    = 32'h00000000;
  localparam logic [31:0] SCM_CNT_RST      = 32'h00000000;
  localparam logic [31:0] SCM_ZERO         = 32'h00000000;
  localparam logic [31:0] SCM_ONE          = 32'h00000001;
  localparam logic [3:0]  SCM_STRB_ALL     = 4'hF;

  // ==========================================================================
  // bus responses
  localparam logic [1:0] SCM_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SCM_RESP_DECERR = 2'h3;

  // ==========================================================================
  // address regions
  typedef enum logic [1:0] {
    SCM_REG_QUERY   = 2'b00,
    SCM_REG_COLLECT = 2'b01,
    SCM_REG_ROUTE   = 2'b10,
    SCM_REG_NONE    = 2'b11
  } scm_region_e;

  // sort a byte address into its region
  function automatic scm_region_e scm_region(input logic [15:0] addr);
    scm_region_e r;
    r = SCM_REG_NONE;
    if (!addr[SCM_ARR_BIT]) begin
      r = addr[SCM_WIN_BIT] ? SCM_REG_COLLECT : SCM_REG_QUERY;
    end else if (addr[15:SCM_IDX_LSB] == SCM_ROUTE_ADDR[15:SCM_IDX_LSB]) begin
      r = SCM_REG_ROUTE;
    end
    return r;
  endfunction

  // counter index carried in a window address
  function automatic logic [11:0] scm_index(input logic [15:0] addr);
    return addr[SCM_IDX_LSB +: SCM_IDX_W];
  endfunction

endpackage

// *** design/scm_counter_array.sv ***
// counter storage: 4096 words with bump, debug write and clearing read
`timescale 1ns/1ns
`default_nettype none
module scm_counter_array (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        bump_valid,
  input  wire logic [11:0] bump_index,
  input  wire logic        rd_en,
  input  wire logic        rd_clear,
  input  wire logic [11:0] rd_index,
  input  wire logic        wr_en,
  input  wire logic [11:0] wr_index,
  input  wire logic [31:0] wr_value,
  output logic      [31:0] rd_value,
  output logic             init_busy
);
  import scm_pkg::*;

  typedef struct packed {
    logic        busy;
    logic [11:0] idx;
    logic [31:0] rd_value;
  } scm_arr_s;

  logic [31:0] mem [SCM_NUM_CNT];
  scm_arr_s    st_reg;
  scm_arr_s    st_next;
  logic [31:0] bump_value;
  logic        bump_go;

  // ==========================================================================
  // bump arithmetic; a clear of the same word, with no write to that word, restarts it at one
  always_comb begin
    bump_go    = bump_valid && !st_reg.busy;
    bump_value = mem[bump_index] + SCM_ONE;
    if (rd_en && rd_clear && rd_index == bump_index &&
        !(wr_en && wr_index == bump_index)) begin
      bump_value = SCM_ONE;
    end
  end

  // ==========================================================================
  // sweep after reset zeroes one word per cycle; saves a 4096-word reset tree
  always_comb begin
    st_next = st_reg;
    if (st_reg.busy) begin
      st_next.idx = st_reg.idx + 12'h001;
      if (st_reg.idx == SCM_LAST_IDX) begin
        st_next.busy = 1'b0;
      end
    end
    if (rd_en) begin
      st_next.rd_value = mem[rd_index];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg <= '{busy: 1'b1, idx: 12'h000, rd_value: SCM_ZERO};
    end else begin
      st_reg <= st_next;
    end
  end

  // later assignments win: bump over debug write over clear
  always_ff @(posedge ref_clk) begin
    if (st_reg.busy) begin
      mem[st_reg.idx] <= SCM_CNT_RST;
    end else begin
      if (rd_en && rd_clear) begin
        mem[rd_index] <= SCM_ZERO;
      end
      if (wr_en) begin
        mem[wr_index] <= wr_value;
      end
      if (bump_go) begin
        mem[bump_index] <= bump_value;
      end
    end
  end

  assign rd_value  = st_reg.rd_value;
  assign init_busy = st_reg.busy;

endmodule
`default_nettype wire

// *** design/scm_stats_counter_memory.sv ***
// statistics counter memory and packet routing register, AXI4-Lite slave
`timescale 1ns/1ns
`default_nettype none
module scm_stats_counter_memory (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic      [1:0]  s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  // counter increment source
  input  wire logic        bump_valid,
  input  wire logic [11:0] bump_index,
  // packet generator side of the routing register
  output logic             route_op_start,
  input  wire logic        route_op_done,
  output logic             operation_go_bit,
  output logic      [4:0]  packet_type_field,
  output logic      [7:0]  flow_index_field,
  output logic      [1:0]  dest_queue_manager,
  output logic      [11:0] dest_queue_number,
  output logic             init_busy
);
  import scm_pkg::*;

  // ==========================================================================
  // state
  typedef enum logic [1:0] {
    SCM_RD_IDLE    = 2'b00,
    SCM_RD_ISSUE   = 2'b01,
    SCM_RD_CAPTURE = 2'b10,
    SCM_RD_RESP    = 2'b11
  } scm_rd_state_e;

  typedef struct packed {
    scm_rd_state_e rd_state;
    logic [15:0]   ar_addr;
    logic          aw_held;
    logic [15:0]   aw_addr;
    logic          w_held;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          bvalid;
    logic [1:0]    bresp;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    logic [31:0]   route;
    logic          start_pulse;
  } scm_state_s;

  scm_state_s  st_reg;
  scm_state_s  st_next;

  // memory port wires
  logic        mem_rd_en;
  logic        mem_rd_clear;
  logic [11:0] mem_rd_index;
  logic        mem_wr_en;
  logic [11:0] mem_wr_index;
  logic [31:0] mem_wr_value;
  logic [31:0] mem_rd_value;
  logic        mem_init_busy;

  // decoded views of the pending requests
  scm_region_e ar_region;
  scm_region_e aw_region;
  logic        write_fire;
  logic [31:0] strb_mask;
  logic [31:0] route_merged;
  logic        go_request;

  // ==========================================================================
  // counter storage
  scm_counter_array u_counters (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .bump_valid (bump_valid),
    .bump_index (bump_index),
    .rd_en      (mem_rd_en),
    .rd_clear   (mem_rd_clear),
    .rd_index   (mem_rd_index),
    .wr_en      (mem_wr_en),
    .wr_index   (mem_wr_index),
    .wr_value   (mem_wr_value),
    .rd_value   (mem_rd_value),
    .init_busy  (mem_init_busy)
  );

  // ==========================================================================
  // handshake outputs; everything waits while the reset sweep runs
  always_comb begin
    s_axi_awready = !st_reg.aw_held && !st_reg.bvalid && !mem_init_busy;
    s_axi_wready  = !st_reg.w_held && !st_reg.bvalid && !mem_init_busy;
    s_axi_arready = (st_reg.rd_state == SCM_RD_IDLE) && !mem_init_busy;
    s_axi_bvalid  = st_reg.bvalid;
    s_axi_rvalid  = (st_reg.rd_state == SCM_RD_RESP);
  end

  // ==========================================================================
  // decode of held addresses and the byte-lane mask
  always_comb begin
    ar_region  = scm_region(st_reg.ar_addr);
    aw_region  = scm_region(st_reg.aw_addr);
    write_fire = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
    for (int b = 0; b < 4; b++) begin
      strb_mask[b*8 +: 8] = {8{st_reg.w_strb[b]}};
    end
    // reserved bits stay zero; the go bit is handled on its own below
    route_merged = (st_reg.route & ~(strb_mask & SCM_ROUTE_RW_MSK)) |
                   (st_reg.w_data & strb_mask & SCM_ROUTE_RW_MSK);
    go_request   = write_fire && (aw_region == SCM_REG_ROUTE) &&
                   st_reg.w_strb[3] && st_reg.w_data[SCM_GO_BIT];
  end

  // ==========================================================================
  // memory port drive: reads in the issue state, writes when both halves held
  always_comb begin
    mem_rd_en    = (st_reg.rd_state == SCM_RD_ISSUE) &&
                   (ar_region == SCM_REG_QUERY ||
                    ar_region == SCM_REG_COLLECT);
    mem_rd_clear = (ar_region == SCM_REG_COLLECT);
    mem_rd_index = scm_index(st_reg.ar_addr);
    // partial-word writes to a counter are dropped: no safe read-modify-write
    mem_wr_en    = write_fire && (st_reg.w_strb == SCM_STRB_ALL) &&
                   (aw_region == SCM_REG_QUERY ||
                    aw_region == SCM_REG_COLLECT);
    mem_wr_index = scm_index(st_reg.aw_addr);
    mem_wr_value = st_reg.w_data;
  end

  // ==========================================================================
  // next-state logic for both channels and the routing register
  always_comb begin
    st_next             = st_reg;
    st_next.start_pulse = 1'b0;

    // write address and data are taken independently, in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_held = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end

    // response once both halves are in
    if (write_fire) begin
      st_next.aw_held = 1'b0;
      st_next.w_held  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = (aw_region == SCM_REG_NONE) ? SCM_RESP_DECERR
                                                    : SCM_RESP_OKAY;
      if (aw_region == SCM_REG_ROUTE) begin
        st_next.route = route_merged;
      end
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    // go bit: a finish report clears it; a fresh start beats that clear,
    // and writing zero while busy cannot cancel the running operation
    if (route_op_done) begin
      st_next.route[SCM_GO_BIT] = 1'b0;
    end
    if (go_request && !(st_reg.route[SCM_GO_BIT] && !route_op_done)) begin
      st_next.route[SCM_GO_BIT] = 1'b1;
      st_next.start_pulse       = 1'b1;
    end

    // read channel
    unique case (st_reg.rd_state)
      SCM_RD_IDLE: begin
        if (s_axi_arvalid && s_axi_arready) begin
          st_next.ar_addr  = s_axi_araddr;
          st_next.rd_state = SCM_RD_ISSUE;
        end
      end
      SCM_RD_ISSUE: begin
        st_next.rd_state = SCM_RD_CAPTURE;
      end
      SCM_RD_CAPTURE: begin
        st_next.rd_state = SCM_RD_RESP;
        st_next.rresp    = SCM_RESP_OKAY;
        unique case (ar_region)
          SCM_REG_QUERY, SCM_REG_COLLECT: begin
            st_next.rdata = mem_rd_value;
          end
          SCM_REG_ROUTE: begin
            st_next.rdata = st_reg.route;
          end
          SCM_REG_NONE: begin
            st_next.rdata = SCM_ZERO;
            st_next.rresp = SCM_RESP_DECERR;
          end
        endcase
      end
      SCM_RD_RESP: begin
        if (s_axi_rready) begin
          st_next.rd_state = SCM_RD_IDLE;
        end
      end
    endcase
  end

  // ==========================================================================
  // state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg <= '{
        rd_state:    SCM_RD_IDLE,
        ar_addr:     16'h0000,
        aw_held:     1'b0,
        aw_addr:     16'h0000,
        w_held:      1'b0,
        w_data:      SCM_ZERO,
        w_strb:      4'h0,
        bvalid:      1'b0,
        bresp:       SCM_RESP_OKAY,
        rdata:       SCM_ZERO,
        rresp:       SCM_RESP_OKAY,
        route:       SCM_ROUTE_RST,
        start_pulse: 1'b0
      };
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // registered outputs; the generator reads the fields only after software
  // has set them up, so no shadow copy is kept
  always_comb begin
    s_axi_bresp        = st_reg.bresp;
    s_axi_rdata        = st_reg.rdata;
    s_axi_rresp        = st_reg.rresp;
    route_op_start     = st_reg.start_pulse;
    operation_go_bit   = st_reg.route[SCM_GO_BIT];
    packet_type_field  = st_reg.route[SCM_PTYPE_HI:SCM_PTYPE_LO];
    flow_index_field   = st_reg.route[SCM_FLOW_HI:SCM_FLOW_LO];
    dest_queue_manager = st_reg.route[SCM_QMGR_HI:SCM_QMGR_LO];
    dest_queue_number  = st_reg.route[SCM_QNUM_HI:SCM_QNUM_LO];
    init_busy          = mem_init_busy;
  end

endmodule
`default_nettype wire

// *** dv/scm_stats_counter_memory_properties.sv ***
// port-level assertions for the statistics counter memory
`timescale 1ns/1ns
`default_nettype none
module scm_stats_counter_memory_properties (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        route_op_start,
  input wire logic        route_op_done,
  input wire logic        operation_go_bit,
  input wire logic        init_busy
);
  import scm_pkg::*;
  // ==========================================================================
  // clocking
  // single domain, so the clock and reset are given once for every check
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // ==========================================================================
  // bus timing
  // read data appears exactly on the third edge after the address is taken
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##1 !s_axi_rvalid
      ##1 s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read latency");
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("no write resp");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("rdata moved");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bresp moved");
  // an error answer never leaks counter contents
  property p_err_zero;
    s_axi_rvalid && s_axi_rresp == SCM_RESP_DECERR |-> s_axi_rdata == SCM_ZERO;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("error data");
  // the zero sweep must not let software see half-cleared counters
  property p_init_quiet;
    init_busy |-> !s_axi_arready && !s_axi_awready && !s_axi_wready;
  endproperty
  a_init_quiet: assert property (p_init_quiet) else $error("ready");

  // ==========================================================================
  // go bit
  property p_start_pulse;
    route_op_start |-> operation_go_bit ##1 !route_op_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start");
  property p_go_rise;
    $rose(operation_go_bit) |-> route_op_start;
  endproperty
  a_go_rise: assert property (p_go_rise) else $error("go no start");
  // nothing but completion may drop a running operation
  property p_go_hold;
    operation_go_bit && !route_op_done |=> operation_go_bit;
  endproperty
  a_go_hold: assert property (p_go_hold) else $error("go dropped");

  c_collect: cover property (s_axi_arvalid && s_axi_arready &&
                             s_axi_araddr[14]);
  c_r_stall: cover property (s_axi_rvalid && !s_axi_rready);
  c_start: cover property (route_op_start);
  c_err: cover property (s_axi_rvalid && s_axi_rresp == SCM_RESP_DECERR);
endmodule
`default_nettype wire

// *** dv/scm_stats_counter_memory_tb.sv ***
// self-checking bench for the statistics counter memory
`timescale 1ns/1ns
`default_nettype none
module scm_stats_counter_memory_tb;
  import scm_pkg::*;
  logic        ref_clk, rst, bump_valid, route_op_done, bump_arm, rdy_lag;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, route_op_start;
  logic        operation_go_bit, init_busy;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d, v, fld;
  logic [3:0]  s_axi_wstrb;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [1:0]  s_axi_bresp, s_axi_rresp, dest_queue_manager, rd_r;
  logic [11:0] bump_index, dest_queue_number, idx;
  logic [4:0]  packet_type_field;
  logic [7:0]  flow_index_field;
  int          fail_count, num_checks, cyc, sweep_n;
  integer      seed;

  scm_stats_counter_memory dut_u (
    .ref_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .bump_valid, .bump_index,
    .route_op_start, .route_op_done, .operation_go_bit, .packet_type_field,
    .flow_index_field, .dest_queue_manager, .dest_queue_number, .init_busy
  );

  // ==========================================================================
  // clock and watchdog
  always #5 ref_clk = ~ref_clk;
  // the 4096-cycle sweep dominates, so the ceiling leaves wide margin
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count = fail_count + 1;
      print_verdict();
    end
  end

  // ==========================================================================
  // helpers
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // byte address of counter n in the query (0) or collect (1) window
  function automatic logic [15:0] win_addr(input logic w, input logic [11:0] n);
    return {1'b0, w, n, 2'b00};
  endfunction
  // routing word as read back: reserved bits 25:24 and 13:12 read zero
  function automatic logic [31:0] route_exp(input logic [31:0] d);
    return d & 32'h7CFFCFFF;
  endfunction
  // write; bump_arm lands a bump in the cycle the memory is written
  task automatic wr(input logic [15:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !rdy_lag;
    while (!(aw_ok && w_ok)) begin
      @(posedge ref_clk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    bump_valid <= bump_arm;
    while (s_axi_bvalid !== 1'b1) begin
      @(posedge ref_clk);
      bump_valid <= 1'b0;
    end
    // a late bready makes the response stand for two cycles
    if (rdy_lag) begin
      @(posedge ref_clk);
      s_axi_bready <= 1'b1;
      @(posedge ref_clk);
    end
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  // read; bump_arm lands a bump in the cycle a collect read clears
  task automatic rd(input logic [15:0] a);
    logic ok;
    ok = 1'b0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !rdy_lag;
    while (!ok) begin
      @(posedge ref_clk);
      ok = (s_axi_arready === 1'b1);
    end
    s_axi_arvalid <= 1'b0;
    bump_valid <= bump_arm;
    while (s_axi_rvalid !== 1'b1) begin
      @(posedge ref_clk);
      bump_valid <= 1'b0;
    end
    // a late rready makes the read data stand for two cycles
    if (rdy_lag) begin
      @(posedge ref_clk);
      s_axi_rready <= 1'b1;
      @(posedge ref_clk);
    end
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    seed = 32'h904D1AB5;
    {ref_clk, bump_valid, route_op_done, bump_arm} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    s_axi_rready = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awprot, s_axi_arprot, bump_index} = '0;
    s_axi_wstrb = SCM_STRB_ALL;
    fail_count = 0;
    num_checks = 0;
    rdy_lag = 1'b0;
    rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    // the zero sweep takes one edge per counter
    sweep_n = 0;
    while (init_busy !== 1'b0) begin
      sweep_n++;
      @(posedge ref_clk);
    end
    chk("sweep_len", SCM_NUM_CNT, sweep_n);
    rd(win_addr(1'b0, 12'h000));
    chk("cnt_first", SCM_ZERO, rd_d);
    chk("rresp_ok", {30'h0, SCM_RESP_OKAY}, {30'h0, rd_r});
    rd(win_addr(1'b1, 12'hFFF));
    chk("cnt_last", SCM_ZERO, rd_d);
    rd(SCM_ROUTE_ADDR);
    chk("route_rst", SCM_ROUTE_RST, rd_d);
    $display("test reset done");
    // load through either window, then query twice, collect, query;
    // half the passes answer late so the outputs must stand
    for (int i = 0; i < 8; i++) begin
      rdy_lag = i[1];
      idx = (i == 0) ? 12'hFFF : 12'($random(seed));
      v = $random(seed);
      wr(win_addr(i[0], idx), v, SCM_RESP_OKAY);
      rd(win_addr(1'b0, idx));
      chk("query1", v, rd_d);
      rd(win_addr(1'b0, idx));
      chk("query2", v, rd_d);
      rd(win_addr(1'b1, idx));
      chk("collect", v, rd_d);
      rd(win_addr(1'b0, idx));
      chk("cleared", SCM_ZERO, rd_d);
    end
    rdy_lag = 1'b0;
    $display("test windows done");
    // bump on the clearing edge, then on the writing edge
    idx = 12'($random(seed));
    v = $random(seed);
    bump_index <= idx;
    wr(win_addr(1'b0, idx), v, SCM_RESP_OKAY);
    bump_arm = 1'b1;
    rd(win_addr(1'b1, idx));
    chk("collect_bump", v, rd_d);
    bump_arm = 1'b0;
    rd(win_addr(1'b0, idx));
    chk("after_clear", SCM_ONE, rd_d);
    bump_arm = 1'b1;
    wr(win_addr(1'b0, idx), v, SCM_RESP_OKAY);
    bump_arm = 1'b0;
    rd(win_addr(1'b0, idx));
    chk("write_vs_bump", 32'h2, rd_d);
    // a partial-lane write to a counter is dropped
    s_axi_wstrb <= 4'h1;
    wr(win_addr(1'b0, idx), v, SCM_RESP_OKAY);
    s_axi_wstrb <= SCM_STRB_ALL;
    rd(win_addr(1'b0, idx));
    chk("part_strb", 32'h2, rd_d);
    $display("test collisions done");
    // routing fields, go bit set, a write with the go bit clear, then completion
    v = $random(seed) & 32'h7FFFFFFF;
    wr(SCM_ROUTE_ADDR, v, SCM_RESP_OKAY);
    rd(SCM_ROUTE_ADDR);
    chk("route", route_exp(v), rd_d);
    fld = {operation_go_bit, packet_type_field, 2'b00, flow_index_field,
           dest_queue_manager, 2'b00, dest_queue_number};
    chk("fields", route_exp(v), fld);
    // the start pulse stands in the cycle the write response appears
    wr(SCM_ROUTE_ADDR, v | 32'h80000000, SCM_RESP_OKAY);
    chk("start", SCM_ONE, {31'h0, route_op_start});
    wr(SCM_ROUTE_ADDR, v, SCM_RESP_OKAY);
    chk("no_restart", SCM_ZERO, {31'h0, route_op_start});
    rd(SCM_ROUTE_ADDR);
    chk("go_held", route_exp(v) | 32'h80000000, rd_d);
    route_op_done <= 1'b1;
    @(posedge ref_clk);
    route_op_done <= 1'b0;
    rd(SCM_ROUTE_ADDR);
    chk("go_done", route_exp(v), rd_d);
    $display("test route done");
    // the word just past the routing register is not mapped
    wr(16'h8004, v, SCM_RESP_DECERR);
    rd(16'h8004);
    chk("err_resp", {30'h0, SCM_RESP_DECERR}, {30'h0, rd_r});
    chk("err_data", SCM_ZERO, rd_d);
    $display("test unmapped done");
    print_verdict();
  end
endmodule

bind scm_stats_counter_memory scm_stats_counter_memory_properties chk_u (
  .ref_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .s_axi_rresp, .route_op_start, .route_op_done, .operation_go_bit, .init_busy
);
`default_nettype wire
